// file: hw/odc_map.vh
`ifndef ODC_MAP_VH
`define ODC_MAP_VH
// ----------------------------------------
// Address, commands, fields, defaults
// ----------------------------------------
`define ODC_ADDR_HI       4'h9
`define ODC_ADDR_BCAST    7'h47
`define ODC_CMD_NOP       4'h0
`define ODC_CMD_CFG       4'h1
`define ODC_CMD_TRIG      4'h2
`define ODC_CMD_BCAST     4'h3
`define ODC_SOFT_RST_CODE 4'ha
`define ODC_GC_ADDR       8'h00
`define ODC_GC_RESET      8'h06
`define ODC_CFG_RESET     16'h00ff
`define ODC_CFG_LOWREF    9
`define ODC_CFG_PD_ALL    8
`define ODC_PART_ID       6'h15
`define ODC_CODE_ZERO     10'h000
`define ODC_BIT_ACK       4'h8
`define ODC_BIT_LAST      4'h7
`define ODC_BIT_PRE       4'hf
`define ODC_STRAP_LOW     3'h0
`define ODC_STRAP_HIGH    3'h1
`define ODC_STRAP_SDA     3'h2
`define ODC_STRAP_SCL     3'h3
`define ODC_STRAP_PIN_RST 2'h0
`endif

// file: hw/odc_octal_dac_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "odc_map.vh"

module odc_octal_dac_ctrl (
	// Clock and reset
	input  wire        REF_CLK,
	input  wire        RST_N,
	// Two-wire bus, pins split into in/out/enable (enable low = drive)
	input  wire        SCL_IN,
	input  wire        SDA_IN,
	output wire        SDA_OUT,
	output wire        SDA_OE_N,
	// Strap level: 0 low, 1 high, 2 tied to data, 3 tied to clock
	input  wire [1:0]  ADDRESS_STRAP_PIN,
	// Control pins
	input  wire        LOAD_STROBE_PIN_N,
	input  wire        ZERO_CODE_PIN_N,
	// Channel outputs
	output wire [79:0] ACTIVE_CODES,
	output reg  [7:0]  CHANNEL_POWERDOWN,
	output reg         LOW_REF
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [1:0] scl_s_r, sda_s_r, ld_s_r, clr_s_r;
	reg [1:0] strap_m_r, strap_q_r;
	reg       scl_d_r, sda_d_r;
	// Two flops per pin before the register logic reads it; the output gate reads ZERO_CODE_PIN_N directly
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			ld_s_r  <= 2'h3;
			clr_s_r <= 2'h3;
			strap_m_r <= `ODC_STRAP_PIN_RST;
			strap_q_r <= `ODC_STRAP_PIN_RST;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], SCL_IN};
			sda_s_r <= {sda_s_r[0], SDA_IN};
			ld_s_r  <= {ld_s_r[0], LOAD_STROBE_PIN_N};
			clr_s_r <= {clr_s_r[0], ZERO_CODE_PIN_N};
			strap_m_r <= ADDRESS_STRAP_PIN;
			strap_q_r <= strap_m_r;
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end

	wire scl      = scl_s_r[1];
	wire sda      = sda_s_r[1];
	wire load_n   = ld_s_r[1];
	wire clear_n  = clr_s_r[1];
	wire scl_rise = scl & ~scl_d_r;
	wire scl_fall = ~scl & scl_d_r;
	wire start_c  = scl & scl_d_r & sda_d_r & ~sda;
	wire stop_c   = scl & scl_d_r & ~sda_d_r & sda;

	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	localparam ST_IDLE = 4'h1;
	localparam ST_ADDR = 4'h2;
	localparam ST_RECV = 4'h4;
	localparam ST_SEND = 4'h8;

	reg [3:0]  state_r;
	reg [3:0]  bitn_r;
	reg [7:0]  shift_r;
	reg [1:0]  byten_r;
	reg [3:0]  cmd_r;
	reg [7:0]  upper_r;
	reg        gcall_r;
	reg        bcast_r;
	reg        sda_low_r;
	reg        ack_out_r;
	reg        load_at_cmd_r;
	reg        strap_sda_r, strap_scl_r;
	reg        soft_rst_r;
	reg [15:0] tx_r;
	reg [15:0] cfg_r;
	reg [9:0]  buf_r [0:7];
	reg [9:0]  act_r [0:7];
	reg [7:0]  pend_r;

	// Strap value to address low bits; data/clock ties decoded from the strap level every clock except a soft-reset clock
	function [2:0] strap_bits;
		input [1:0] strap;
		input       seen_sda, seen_scl;
		begin
			if (seen_scl)
				strap_bits = `ODC_STRAP_SCL;
			else if (seen_sda)
				strap_bits = `ODC_STRAP_SDA;
			else if (strap[0])
				strap_bits = `ODC_STRAP_HIGH;
			else
				strap_bits = `ODC_STRAP_LOW;
		end
	endfunction

	// Readback word for a command
	function [15:0] read_word;
		input [3:0]  cmd;
		input [15:0] cfg;
		input [9:0]  code;
		begin
			if (cmd[3])
				read_word = {4'h0, code, 2'h0};
			else if (cmd == `ODC_CMD_CFG)
				read_word = cfg;
			else if (cmd == `ODC_CMD_TRIG)
				read_word = {4'h0, `ODC_PART_ID, 6'h00};
			else
				read_word = 16'h0000;
		end
	endfunction

	wire [6:0]  my_addr = {`ODC_ADDR_HI, strap_bits(strap_q_r, strap_sda_r, strap_scl_r)};
	wire [15:0] rd_word = read_word(cmd_r, cfg_r, buf_r[cmd_r[2:0]]);
	wire [7:0] rx_byte  = shift_r;
	wire       ack_fall = scl_fall & (bitn_r == `ODC_BIT_ACK);
	wire       soft_rst = soft_rst_r;

	// ----------------------------------------
	// Bus engine, registers and update
	// ----------------------------------------
	integer i;
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r       <= ST_IDLE;
			bitn_r        <= 4'h0;
			shift_r       <= 8'h00;
			byten_r       <= 2'h0;
			cmd_r         <= `ODC_CMD_NOP;
			upper_r       <= 8'h00;
			gcall_r       <= 1'b0;
			bcast_r       <= 1'b0;
			sda_low_r     <= 1'b0;
			ack_out_r     <= 1'b0;
			load_at_cmd_r <= 1'b1;
			strap_sda_r   <= 1'b0;
			strap_scl_r   <= 1'b0;
			soft_rst_r    <= 1'b0;
			tx_r          <= 16'h0000;
			cfg_r         <= `ODC_CFG_RESET;
			pend_r        <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				buf_r[i] <= `ODC_CODE_ZERO;
				act_r[i] <= `ODC_CODE_ZERO;
			end
		end else if (soft_rst) begin
			// Soft or general-call reset: power-on defaults, except the shift register and strap ties keep their values
			state_r   <= ST_IDLE;
			bitn_r    <= 4'h0;
			byten_r   <= 2'h0;
			sda_low_r <= 1'b0;
			soft_rst_r <= 1'b0;
			cmd_r     <= `ODC_CMD_NOP;
			upper_r   <= 8'h00;
			gcall_r   <= 1'b0;
			bcast_r   <= 1'b0;
			ack_out_r <= 1'b0;
			load_at_cmd_r <= 1'b1;
			tx_r      <= 16'h0000;
			cfg_r     <= `ODC_CFG_RESET;
			pend_r    <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				buf_r[i] <= `ODC_CODE_ZERO;
				act_r[i] <= `ODC_CODE_ZERO;
			end
		end else begin
			// Synchronous-mode load: all pending channels at once
			if (!load_n) begin
				for (i = 0; i < 8; i = i + 1)
					if (pend_r[i])
						act_r[i] <= buf_r[i];
				pend_r <= 8'h00;
			end
			if (start_c) begin
				state_r     <= ST_ADDR;
				bitn_r      <= `ODC_BIT_PRE;  // Clock fall ending the start is no bit
				byten_r     <= 2'h0;
				sda_low_r   <= 1'b0;
			end else if (stop_c) begin
				state_r   <= ST_IDLE;
				sda_low_r <= 1'b0;
			end else if (state_r != ST_IDLE) begin
				if (scl_rise && bitn_r != `ODC_BIT_ACK)
					shift_r <= {shift_r[6:0], sda};
				if (scl_rise && bitn_r == `ODC_BIT_ACK && state_r == ST_SEND && sda)
					state_r <= ST_IDLE;  // Master refused more data
				if (scl_fall) begin
					bitn_r <= (bitn_r == `ODC_BIT_ACK) ? 4'h0 : bitn_r + 4'h1;
					sda_low_r <= 1'b0;
					if (bitn_r == `ODC_BIT_LAST) begin
						// End of eighth clock: decide acknowledge for the ninth
						case (state_r)
						ST_ADDR: begin
							gcall_r <= (rx_byte == `ODC_GC_ADDR);
							bcast_r <= (rx_byte[7:1] == `ODC_ADDR_BCAST);
							if ((rx_byte[7:1] == my_addr) ||
							    (rx_byte[7:1] == `ODC_ADDR_BCAST && !rx_byte[0]) ||
							    (rx_byte == `ODC_GC_ADDR)) begin
								sda_low_r <= 1'b1;
								ack_out_r <= rx_byte[0];
							end else begin
								state_r <= ST_IDLE;
							end
						end
						ST_RECV: begin
							sda_low_r <= 1'b1;
							if (byten_r == 2'h0 && !gcall_r) begin
								cmd_r         <= rx_byte[3:0];
								load_at_cmd_r <= load_n;
							end else if (byten_r == 2'h1) begin
								upper_r <= rx_byte;
							end
						end
						ST_SEND: begin
							sda_low_r <= 1'b0;
						end
						default: begin
							sda_low_r <= 1'b0;
						end
						endcase
					end
					// Transmit: next bit goes out while clock low; ninth slot released
					if (state_r == ST_SEND && bitn_r != `ODC_BIT_LAST) begin
						sda_low_r <= ~tx_r[15];
						tx_r      <= {tx_r[14:0], 1'b0};
					end
				end
				// End of acknowledge clock: act on the byte
				if (ack_fall) begin
					if (state_r == ST_ADDR) begin
						state_r <= ack_out_r ? ST_SEND : ST_RECV;
						if (ack_out_r) begin
							// First bit goes out as the address acknowledge ends
							sda_low_r <= ~rd_word[15];
							tx_r      <= {rd_word[14:0], 1'b0};
						end
					end else if (state_r == ST_RECV) begin
						byten_r <= (byten_r == 2'h2) ? 2'h1 : byten_r + 2'h1;
						if (gcall_r && byten_r == 2'h0 && rx_byte == `ODC_GC_RESET)
							soft_rst_r <= 1'b1;
						if (!gcall_r && byten_r == 2'h2) begin
							// Lower data byte taken: apply update
							if (cmd_r[3]) begin
								buf_r[cmd_r[2:0]] <= {upper_r[3:0], rx_byte[7:2]};
								if (!load_at_cmd_r)
									act_r[cmd_r[2:0]] <= {upper_r[3:0], rx_byte[7:2]};
								else
									pend_r[cmd_r[2:0]] <= 1'b1;
							end else if (cmd_r == `ODC_CMD_BCAST) begin
								for (i = 0; i < 8; i = i + 1) begin
									buf_r[i] <= {upper_r[3:0], rx_byte[7:2]};
									if (!load_at_cmd_r)
										act_r[i] <= {upper_r[3:0], rx_byte[7:2]};
									else
										pend_r[i] <= 1'b1;
								end
							end else if (cmd_r == `ODC_CMD_CFG && !bcast_r) begin
								cfg_r <= {upper_r, rx_byte};
							end else if (cmd_r == `ODC_CMD_CFG) begin
								cfg_r <= {upper_r, rx_byte};
							end else if (cmd_r == `ODC_CMD_TRIG &&
							             rx_byte[3:0] == `ODC_SOFT_RST_CODE) begin
								soft_rst_r <= 1'b1;
							end
						end
					end
				end
			end
			// Strap decode from the synchronised strap level
			strap_sda_r <= ({1'b0, strap_q_r} == `ODC_STRAP_SDA);
			strap_scl_r <= ({1'b0, strap_q_r} == `ODC_STRAP_SCL);
			// Clear held low: buffers, active codes and pending loads zeroed, clear wins
			if (!clear_n) begin
				for (i = 0; i < 8; i = i + 1) begin
					buf_r[i] <= `ODC_CODE_ZERO;
					act_r[i] <= `ODC_CODE_ZERO;
				end
				pend_r <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: only ever pulls low
	assign SDA_OUT  = 1'b0;
	assign SDA_OE_N = ~sda_low_r;

	// Clear pin overrides channel codes asynchronously
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_out
			assign ACTIVE_CODES[g*10 +: 10] = ZERO_CODE_PIN_N ? act_r[g] : `ODC_CODE_ZERO;
		end
	endgenerate

	// Power-down and low-reference from configuration
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CHANNEL_POWERDOWN <= 8'hff;
			LOW_REF           <= 1'b0;
		end else begin
			CHANNEL_POWERDOWN <= cfg_r[7:0] | {8{cfg_r[`ODC_CFG_PD_ALL]}};
			LOW_REF           <= cfg_r[`ODC_CFG_LOWREF];
		end
	end

endmodule // odc_octal_dac_ctrl
`default_nettype wire

// file: verif/odc_i2c_master.sv
`timescale 1ns/100ps
`default_nettype none
module odc_i2c_master (
	// Bus lines, data open-drain (1 releases)
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	// ----
	// Bus idles high, clock still outside frames
	// ----
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// One bit: data set with clock low, sampled in clock high
	task automatic bit1(input logic b, output logic r);
		sda_drv = b;
		#20 scl = 1'b1;
		#20 r = sda;
		#20 scl = 1'b0;
		#20;
	endtask
	// Start or repeated start
	task automatic start();
		sda_drv = 1'b1;
		#20 scl = 1'b1;
		#20 sda_drv = 1'b0;
		#20 scl = 1'b0;
		#20;
	endtask
	// Stop: data rises with clock high
	task automatic stop();
		sda_drv = 1'b0;
		#20 scl = 1'b1;
		#20 sda_drv = 1'b1;
		#20;
	endtask
	// Send a byte, return acknowledge level
	task automatic put(input logic [7:0] d, output logic nack);
		for (int i = 7; i >= 0; i--) bit1(d[i], nack);
		bit1(1'b1, nack);
	endtask
	// Receive a byte, then acknowledge unless last
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit1(1'b1, r);
			d[i] = r;
		end
		bit1(last, r);
	endtask
endmodule // odc_i2c_master
`default_nettype wire

// file: verif/odc_octal_dac_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module odc_octal_dac_ctrl_sva (
	// Clock, reset and bus
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic        SCL_IN,
	input wire logic        SDA_IN,
	input wire logic        SDA_OUT,
	input wire logic        SDA_OE_N,
	// Strap and control pins
	input wire logic [1:0]  ADDRESS_STRAP_PIN,
	input wire logic        LOAD_STROBE_PIN_N,
	input wire logic        ZERO_CODE_PIN_N,
	// Channel outputs
	input wire logic [79:0] ACTIVE_CODES,
	input wire logic [7:0]  CHANNEL_POWERDOWN,
	input wire logic        LOW_REF
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// ----
	// Reset, clear, bus drive and output hold
	// ----
	a_reset_zero_codes: assert property ($rose(RST_N) |-> ACTIVE_CODES == 80'h0)
		else $error("codes not zero after reset");
	a_reset_powered_down: assert property ($rose(RST_N) |-> CHANNEL_POWERDOWN == 8'hff)
		else $error("outputs not powered down after reset");
	a_clear_forces_zero: assert property (!ZERO_CODE_PIN_N |-> ACTIVE_CODES == 80'h0)
		else $error("clear pin did not zero codes");
	a_data_open_drain: assert property (SDA_OUT == 1'b0)
		else $error("data line driven high");
	a_drive_clock_low: assert property ($fell(SDA_OE_N) |-> !SCL_IN)
		else $error("data drive began with clock high");
	a_release_clock_low: assert property ($rose(SDA_OE_N) |-> !SCL_IN)
		else $error("data released with clock high");
	a_ack_stands: assert property (SCL_IN [*5] |-> $stable(SDA_OE_N))
		else $error("data drive moved in clock high");
	a_codes_hold: assert property ((SCL_IN && LOAD_STROBE_PIN_N && ZERO_CODE_PIN_N) [*6]
		|-> $stable(ACTIVE_CODES))
		else $error("codes moved outside an update");
	a_config_hold: assert property (SCL_IN [*6] |-> $stable({CHANNEL_POWERDOWN, LOW_REF}))
		else $error("config moved in clock high");
	// Main scenarios reached
	c_ack: cover property ($fell(SDA_OE_N));
	c_code: cover property (ACTIVE_CODES != 80'h0);
	c_power_up: cover property ($fell(CHANNEL_POWERDOWN[0]));
endmodule // odc_octal_dac_ctrl_sva
`default_nettype wire

// file: verif/odc_octal_dac_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module odc_octal_dac_ctrl_tb;
	logic        ref_clk, rst_n, load_n, zero_n, ack_n;
	logic [1:0]  strap;
	logic [15:0] rd;
	wire  [79:0] codes;
	wire  [7:0]  pdown;
	wire         low_ref, sda_oe_n, sda_out, scl, sda_drv, sda;
	int          fail_count, comparisons;
	// Wired-and data line with pull-up
	assign sda = sda_drv & (sda_oe_n | sda_out);
	odc_octal_dac_ctrl odc_octal_dac_ctrl_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_STRAP_PIN(strap),
		.LOAD_STROBE_PIN_N(load_n), .ZERO_CODE_PIN_N(zero_n), .ACTIVE_CODES(codes),
		.CHANNEL_POWERDOWN(pdown), .LOW_REF(low_ref));
	odc_i2c_master odc_i2c_master_inst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	// ----
	// Checking and bus tasks
	// ----
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Write frame of nb bytes: address, command, upper, lower
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, input int nb);
		logic [31:0] f;
		logic        n;
		f = {a, 1'b0, c, w};
		ack_n = 1'b0;
		odc_i2c_master_inst.start();
		for (int i = 0; i < nb; i++) begin
			odc_i2c_master_inst.put(f[31 - 8 * i -: 8], n);
			ack_n = ack_n | n;
		end
		odc_i2c_master_inst.stop();
		repeat (10) @(negedge ref_clk);
	endtask
	// Read the word of the last written command
	task automatic rdw(input logic [6:0] a);
		logic n;
		odc_i2c_master_inst.start();
		odc_i2c_master_inst.put({a, 1'b1}, n);
		odc_i2c_master_inst.get(1'b0, rd[15:8]);
		odc_i2c_master_inst.get(1'b1, rd[7:0]);
		odc_i2c_master_inst.stop();
	endtask
	// Clock at 4 ns
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Watchdog on the whole run
	initial begin
		#300000;
		fail_count++;
		end_of_test();
	end
	// ----
	// Test sequence
	// ----
	initial begin
		fail_count = 0;
		comparisons = 0;
		{rst_n, load_n, zero_n, strap} = 5'b00100;
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("pdown", {8'h0, pdown}, 16'h00ff);
		chk("lowref", {15'h0, low_ref}, 16'h0000);
		chk("codes", {15'h0, |codes}, 16'h0000);
		$display("test reset done");
		wr(7'h48, 8'h01, 16'h0200, 4);
		chk("ack", {15'h0, ack_n}, 16'h0000);
		chk("pdown", {8'h0, pdown}, 16'h0000);
		chk("lowref", {15'h0, low_ref}, 16'h0001);
		rdw(7'h48);
		chk("cfg read", rd, 16'h0200);
		wr(7'h48, 8'h0a, {4'h0, 10'h2a5, 2'h0}, 4);
		chk("ch c", {6'h0, codes[29:20]}, 16'h02a5);
		$display("test immediate done");
		load_n = 1'b1;
		wr(7'h48, 8'h0f, {4'h0, 10'h3ff, 2'h0}, 4);
		chk("ch h", {6'h0, codes[79:70]}, 16'h0000);
		rdw(7'h48);
		chk("read", {6'h0, rd[11:2]}, 16'h03ff);
		load_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		chk("ch h", {6'h0, codes[79:70]}, 16'h03ff);
		chk("ch c", {6'h0, codes[29:20]}, 16'h02a5);
		$display("test load done");
		wr(7'h49, 8'h08, 16'h0040, 4);
		chk("nack", {15'h0, ack_n}, 16'h0001);
		chk("ch a", {6'h0, codes[9:0]}, 16'h0000);
		strap = 2'h1;
		wr(7'h49, 8'h08, 16'h0004, 4);
		chk("ch a", {6'h0, codes[9:0]}, 16'h0001);
		wr(7'h47, 8'h00, 16'h0000, 4);
		chk("bcast", {15'h0, ack_n}, 16'h0000);
		strap = 2'h3;
		wr(7'h4b, 8'h08, 16'h0008, 4);
		chk("ch a", {6'h0, codes[9:0]}, 16'h0002);
		strap = 2'h1;
		$display("test address done");
		zero_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("clear", {15'h0, |codes}, 16'h0000);
		zero_n = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk("clear", {15'h0, |codes}, 16'h0000);
		$display("test clear done");
		wr(7'h49, 8'h08, 16'h0800, 4);
		wr(7'h49, 8'h02, 16'h000a, 4);
		chk("pdown", {8'h0, pdown}, 16'h00ff);
		chk("codes", {15'h0, |codes}, 16'h0000);
		chk("lowref", {15'h0, low_ref}, 16'h0000);
		wr(7'h49, 8'h01, 16'h0000, 4);
		wr(7'h49, 8'h09, 16'h0800, 4);
		wr(7'h00, 8'h06, 16'h0000, 2);
		chk("pdown", {8'h0, pdown}, 16'h00ff);
		chk("codes", {15'h0, |codes}, 16'h0000);
		wr(7'h49, 8'h03, {4'h0, 10'h155, 2'h0}, 4);
		chk("bcast data", {6'h0, codes[49:40]}, 16'h0155);
		$display("test resets done");
		end_of_test();
	end
endmodule // odc_octal_dac_ctrl_tb
bind odc_octal_dac_ctrl odc_octal_dac_ctrl_sva odc_octal_dac_ctrl_sva_inst (.REF_CLK(REF_CLK),
	.RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
	.ADDRESS_STRAP_PIN(ADDRESS_STRAP_PIN), .LOAD_STROBE_PIN_N(LOAD_STROBE_PIN_N),
	.ZERO_CODE_PIN_N(ZERO_CODE_PIN_N), .ACTIVE_CODES(ACTIVE_CODES),
	.CHANNEL_POWERDOWN(CHANNEL_POWERDOWN), .LOW_REF(LOW_REF));
`default_nettype wire
